// File: verif/smpsc_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side: low power command, chip select, pulls on the wake wires
module smpsc_host (
	input wire logic i_clk, // Core clock
	input wire logic i_cs_woke, // Device reports a select wake
	output logic o_lpm_cmd, // Enter low power command
	output logic o_cs_n, // Chip select
	output logic o_int_n, // Pull on interrupt wire, low pulls
	output logic o_wake_n // Pull on wake wire, low pulls
);
	logic drop_reply; // Next serial reply is thrown away
	initial begin
		o_lpm_cmd = 1'b0;
		o_cs_n = 1'b1;
		o_int_n = 1'b1;
		o_wake_n = 1'b1;
	end
	// A reply right after a select wake is not trusted
	assign drop_reply = (i_cs_woke === 1'b1);
	// Only way to ask for low power
	task automatic sleep();
		o_lpm_cmd = 1'b1;
	endtask : sleep
	// Pull one line low: 0 select, 1 interrupt, 2 wake
	task automatic drop(input int p);
		o_cs_n = (p != 0);
		o_int_n = (p != 1);
		o_wake_n = (p != 2);
	endtask : drop
	// Release every line
	task automatic lift();
		o_lpm_cmd = 1'b0;
		o_cs_n = 1'b1;
		o_int_n = 1'b1;
		o_wake_n = 1'b1;
	endtask : lift
endmodule : smpsc_host
`default_nettype wire

// File: verif/switch_monitor_power_state_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the operating-state controller
module switch_monitor_power_state_ctrl_tb;
	localparam int N = smpsc_pkg::NUM_INPUTS;
	localparam int T = smpsc_pkg::SLOW_DIV;
	localparam logic [5:0] FUS = smpsc_pkg::ST_FUSE;
	localparam logic [5:0] NRM = smpsc_pkg::ST_NORMAL;
	localparam logic [5:0] LOW_POWER_STATE = smpsc_pkg::ST_LPM;
	localparam logic [5:0] PLL = smpsc_pkg::ST_POLL;
	logic clk, rst_n = 1'b0, bat_uv = 1'b1, io_ok = 1'b1, wpe = 1'b1;
	logic twarn = 1'b0, fclr = 1'b0, lpm_cmd, cs_n, h_int, h_wake;
	logic [N-1:0] wen = '0, cfg = '0, above = '0, csrc, closed;
	logic [15:0] iper = 16'h0000, pper = 16'h0000;
	logic [7:0] win = 8'h02;
	logic [3:0] hot = 4'h0;
	logic [2:0] wet = 3'h5, wsel;
	logic [5:0] st;
	logic spi, miso_n, analog_mux_out, fosc, sosc, rail, fdet, pact, wout, woe_n;
	logic iout, ioe_n, wev, cswoke, tl, tw, int_n, wake_n;
	int fails = 0;
	int checks = 0;
	// Pulled-up wires, low when either side pulls
	assign int_n = (ioe_n ? 1'b1 : iout) & h_int;
	assign wake_n = (woe_n ? 1'b1 : wout) & h_wake;
	smpsc_ctrl #(.N(N), .NT(4)) DUT (
		.I_CLK(clk), .I_RST_N(rst_n), .I_BAT_UV(bat_uv),
		.I_IO_SUPPLY_OK(io_ok), .I_LPM_CMD(lpm_cmd), .I_CS_N(cs_n),
		.I_INT_IN_N(int_n), .I_WAKE_IN_N(wake_n), .I_WAKE_PIN_EN(wpe),
		.I_INPUT_WAKE_EN(wen), .I_BAT_CFG(cfg), .I_COMP_ABOVE(above),
		.I_INT_TMR_PERIOD(iper), .I_POLL_TMR_PERIOD(pper),
		.I_POLL_WIN(win), .I_HOT_CELLS(hot), .I_TWARN(twarn),
		.I_FAULT_CLR(fclr), .I_WET_SEL(wet), .O_STATE(st),
		.O_SPI_EN(spi), .O_MISO_OE_N(miso_n), .O_ANALOG_MUX_OUT_EN(analog_mux_out),
		.O_CUR_SRC_EN(csrc), .O_FAST_OSC_EN(fosc), .O_SLOW_OSC_EN(sosc),
		.O_RAIL_EN(rail), .O_FAULT_DET_EN(fdet), .O_POLL_ACTIVE(pact),
		.O_WAKE_OUT(wout), .O_WAKE_OE_N(woe_n), .O_INT_OUT(iout),
		.O_INT_OE_N(ioe_n), .O_WAKE_EVENT(wev), .O_CS_WOKE(cswoke),
		.O_SWITCH_CLOSED(closed), .O_HOT_FAULT(tl), .O_TWARN_FLAG(tw),
		.O_WET_SEL(wsel));
	smpsc_host host (.i_clk(clk), .i_cs_woke(cswoke), .o_lpm_cmd(lpm_cmd),
		.o_cs_n(cs_n), .o_int_n(h_int), .o_wake_n(h_wake));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Compare tasks: one flag, one vector, one state
	task automatic chk_b(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp %h got %h", $time, exp, got);
		end
	endtask : chk_b
	task automatic chk_v(input logic [N-1:0] got, input logic [N-1:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp %h got %h", $time, exp, got);
		end
	endtask : chk_v
	task automatic chk_st(input logic [5:0] s);
		chk_v({16'h0, st}, {16'h0, s});
	endtask : chk_st
	// Wait a bounded time for a state
	task automatic wait_st(input logic [5:0] s, input int lim);
		int n;
		n = 0;
		while (st !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk_st(s);
	endtask : wait_st
	task automatic go_lpm();
		@(negedge clk);
		host.sleep();
		@(negedge clk);
		host.lift();
		chk_st(LOW_POWER_STATE);
		chk_b(fosc | rail | fdet | spi | ~woe_n, 1'b0);
		chk_v(csrc, '0);
	endtask : go_lpm
	// Select frame in normal mode clears a pending interrupt
	task automatic clr();
		@(negedge clk);
		host.drop(0);
		repeat (2) @(negedge clk);
		host.lift();
		@(negedge clk);
	endtask : clr
	// Watch for any activity while low power should hold
	task automatic calm(input int p, input int cyc, output logic seen);
		seen = 1'b0;
		@(negedge clk);
		if (p >= 0)
			host.drop(p);
		repeat (cyc) begin
			@(negedge clk);
			seen = seen | pact | wev | (st !== LOW_POWER_STATE);
		end
		host.lift();
		@(negedge clk);
	endtask : calm
	task automatic t_power();
		int n;
		n = 0;
		chk_st(6'h01);
		chk_b(sosc | fosc | rail | spi, 1'b0);
		rst_n = 1'b1;
		@(negedge clk);
		chk_st(6'h02);
		chk_b(spi | analog_mux_out | ~miso_n, 1'b0);
		chk_v(csrc, '0);
		chk_b(fosc & sosc, 1'b1);
		bat_uv = 1'b0;
		host.sleep();
		@(negedge clk);
		host.lift();
		chk_st(FUS);
		while (st === FUS && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk_v(N'(n), N'(smpsc_pkg::FUSE_CYCLES));
		chk_st(NRM);
		chk_b(woe_n | wout, 1'b0);
		cfg = 22'h3C00FF;
		above = 22'h0F0F0F;
		repeat (2) @(negedge clk);
		chk_v(closed, (cfg & above) | (~cfg & ~above));
		cfg = '0;
		above = '0;
		$display("power and input test done");
	endtask : t_power
	task automatic t_therm();
		for (int i = 0; i < 4; i++) begin
			hot = 4'h1 << i;
			@(negedge clk);
			chk_b(tl, 1'b1);
			chk_v({19'h0, wsel}, {19'h0, smpsc_pkg::WET_MIN});
			hot = 4'h0;
			fclr = 1'b1;
			@(negedge clk);
			fclr = 1'b0;
			chk_v({18'h0, tl, wsel}, {18'h0, 1'b0, wet});
		end
		twarn = 1'b1;
		@(negedge clk);
		chk_b(tw & ~tl, 1'b1);
		twarn = 1'b0;
		fclr = 1'b1;
		@(negedge clk);
		fclr = 1'b0;
		go_lpm();
		hot = 4'h3;
		twarn = 1'b1;
		repeat (4) @(negedge clk);
		hot = 4'h0;
		twarn = 1'b0;
		host.drop(0);
		wait_st(NRM, 3);
		chk_b(tl | tw, 1'b0);
		host.lift();
		clr();
		$display("thermal test done");
	endtask : t_therm
	task automatic t_pins();
		logic seen;
		io_ok = 1'b0;
		go_lpm();
		for (int p = 0; p < 3; p++) begin
			calm(p, 4, seen);
			chk_b(seen, 1'b0);
		end
		io_ok = 1'b1;
		wpe = 1'b0;
		calm(2, 4, seen);
		chk_b(seen, 1'b0);
		wpe = 1'b1;
		for (int p = 0; p < 3; p++) begin
			@(negedge clk);
			host.drop(p);
			wait_st(NRM, 3);
			chk_b(wev, 1'b1);
			chk_b(woe_n | wout, 1'b0);
			chk_b(cswoke, p == 0);
			chk_b(host.drop_reply, p == 0);
			host.lift();
			clr();
			if (p < 2)
				go_lpm();
		end
		$display("pin wake test done");
	endtask : t_pins
	task automatic t_timer();
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		iper = 16'h0002;
		pper = 16'h0002;
		wen = 22'h1;
		go_lpm();
		while (st === LOW_POWER_STATE && n < 3 * T) begin
			@(negedge clk);
			seen = seen | pact;
			n++;
		end
		chk_st(NRM);
		chk_b(ioe_n, 1'b0);
		chk_b(n > T && n < 2 * T + 14, 1'b1);
		chk_b(seen, 1'b0);
		iper = 16'h0000;
		clr();
		$display("timer test done");
	endtask : t_timer
	task automatic t_poll();
		logic seen;
		above = 22'h2;
		wen = 22'h3;
		pper = 16'h0001;
		go_lpm();
		wait_st(PLL, T + 4);
		chk_v(csrc, 22'h1);
		chk_b(rail & pact, 1'b1);
		wait_st(LOW_POWER_STATE, 4 * T);
		bat_uv = 1'b1;
		calm(-1, 3 * T, seen);
		chk_b(seen, 1'b0);
		bat_uv = 1'b0;
		wen = '0;
		calm(-1, 3 * T, seen);
		chk_b(seen, 1'b0);
		wen = 22'h3;
		above = 22'h3;
		wait_st(NRM, 5 * T);
		chk_b(wev, 1'b1);
		pper = 16'h0000;
		clr();
		$display("poll test done");
	endtask : t_poll
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Main sequence after four reset cycles
	initial begin
		repeat (4) @(negedge clk);
		t_power();
		t_therm();
		t_pins();
		t_timer();
		t_poll();
		report_and_stop();
	end
	// Watchdog: tests need about 5500 cycles, allow 40000
	initial begin
		#(40000 * 25);
		fails++;
		report_and_stop();
	end
endmodule : switch_monitor_power_state_ctrl_tb
`default_nettype wire

// File: verilog/smpsc_ctrl.sv
// Operation
// [RULE1] Below the power-on threshold the block stays in reset, doing nothing.
// [RULE2] Undervoltage keeps registers, blocks serial port, MISO, mux, sources.
// [RULE3] Both oscillators run once the undervoltage state is reached.
// [RULE4] Battery above threshold: read fuses about 50 us, then normal.
// [RULE5] In normal mode the wake pin is driven low.
// [RULE6] Low power is entered only by the dedicated serial command.
// [RULE7] Low power stops rails, fast oscillator, fault detectors; faults unrecorded. Rails stay on in the poll window.
// [RULE8] Settings made in normal mode survive low power unchanged.
// [RULE9] Input change, timer, wake pin, interrupt, chip select, reset wake.
// [RULE10] Pin edges wake only with I/O supply present; else stay silent.
// [RULE11] Without I/O supply interrupt and chip-select edges cannot wake.
// [RULE12] Host discards first serial answer after a chip-select wake.
// [RULE13] Interrupt timer expiry in low power raises interrupt, wakes.
// [RULE14] Polling timer periodically opens an active window checking inputs.
// [RULE15] Poll and interrupt timer together: wake on timer, skip poll.
// [RULE16] Input open at entry and still open skips the rest of poll.
// [RULE17] Battery undervoltage in low power pauses polling without waking.
// [RULE18] No input wake enabled: no input wake, polling timer disabled.
// [RULE19] Above threshold reads open for ground switch, closed for battery.
// [RULE20] All thermal-limit cells ORed into one reported fault.
// [RULE21] Thermal limit forces minimum wetting current; sustain untouched.
// [RULE22] Thermal warning flag is set independently of the limit fault.
// [RULE23] Valid wake returns to normal and drives wake pin low.
// [RULE24] Timers count slow-oscillator ticks so they run in low power.
`timescale 1ns/10ps
`default_nettype none
module smpsc_ctrl #(
	parameter int N = smpsc_pkg::NUM_INPUTS,
	parameter int NT = smpsc_pkg::HOT_CELLS
) (
	input wire logic I_CLK, // 40 MHz core clock
	input wire logic I_RST_N, // Power-on reset, active low
	input wire logic I_BAT_UV, // Battery supply in undervoltage
	input wire logic I_IO_SUPPLY_OK, // I/O supply present
	input wire logic I_LPM_CMD, // Enter low power command pulse
	input wire logic I_CS_N, // Chip select pin level
	input wire logic I_INT_IN_N, // Interrupt pin level
	input wire logic I_WAKE_IN_N, // Wake pin level
	input wire logic I_WAKE_PIN_EN, // Wake pin may wake the device
	input wire logic [N-1:0] I_INPUT_WAKE_EN, // Per-input wake enables
	input wire logic [N-1:0] I_BAT_CFG, // 1: battery switch input
	input wire logic [N-1:0] I_COMP_ABOVE, // Comparator above threshold
	input wire logic [15:0] I_INT_TMR_PERIOD, // Slow ticks, 0 disables
	input wire logic [15:0] I_POLL_TMR_PERIOD, // Slow ticks, 0 disables
	input wire logic [7:0] I_POLL_WIN, // Poll window in slow ticks
	input wire logic [NT-1:0] I_HOT_CELLS, // Thermal-limit detectors
	input wire logic I_TWARN, // Thermal warning detector
	input wire logic I_FAULT_CLR, // Clear sticky thermal flags
	input wire logic [2:0] I_WET_SEL, // Requested wetting current
	output logic [5:0] O_STATE, // Current operating state
	output logic O_SPI_EN, // Serial port accepts frames
	output logic O_MISO_OE_N, // MISO enable, low drives
	output logic O_ANALOG_MUX_OUT_EN, // Analog mux active
	output logic [N-1:0] O_CUR_SRC_EN, // Per-input current sources
	output logic O_FAST_OSC_EN, // Fast oscillator enable
	output logic O_SLOW_OSC_EN, // Slow oscillator enable
	output logic O_RAIL_EN, // Main internal rails enable
	output logic O_FAULT_DET_EN, // Fault detectors enable
	output logic O_POLL_ACTIVE, // Poll active window
	output logic O_WAKE_OUT, // Wake pin output level
	output logic O_WAKE_OE_N, // Wake pin enable, low drives
	output logic O_INT_OUT, // Interrupt pin output level
	output logic O_INT_OE_N, // Interrupt pin enable, low drives
	output logic O_WAKE_EVENT, // Wake reported, one cycle
	output logic O_CS_WOKE, // Woken by chip select
	output logic [N-1:0] O_SWITCH_CLOSED, // Input closed status
	output logic O_HOT_FAULT, // Sticky thermal-limit fault
	output logic O_TWARN_FLAG, // Sticky thermal warning
	output logic [2:0] O_WET_SEL // Applied wetting current
);
	typedef struct packed {
		smpsc_pkg::smpsc_state_t st;
		logic [smpsc_pkg::FUSE_W-1:0] fuse_cnt;
		logic [smpsc_pkg::TMR_W-1:0] int_cnt;
		logic [smpsc_pkg::TMR_W-1:0] poll_cnt;
		logic [smpsc_pkg::WIN_W-1:0] win_cnt;
		logic [N-1:0] snap;
		logic [N-1:0] skip;
		logic [N-1:0] closed;
		logic [2:0] wet;
		logic cs_q;
		logic int_q;
		logic wake_q;
		logic int_req;
		logic wake_evt;
		logic cs_woke;
		logic hot;
		logic twarn;
	} smpsc_ctrl_st_t;

	localparam logic [smpsc_pkg::FUSE_W-1:0] FUSE_LAST =
		smpsc_pkg::FUSE_W'(smpsc_pkg::FUSE_CYCLES - 1);
	localparam logic [smpsc_pkg::TMR_W-1:0] TMR_ONE = 16'h0001;

	smpsc_ctrl_st_t s;
	smpsc_ctrl_st_t next_s;
	logic tick;
	logic [N-1:0] closed_now;
	logic any_wake_en;
	logic is_normal;
	logic is_low;
	logic cs_fall;
	logic int_fall;
	logic wake_fall;
	logic pin_wake;
	logic int_exp;
	logic poll_exp;
	logic poll_run;
	logic hot_now;
	logic in_change;

	// Always-running slow time base for low-power timers
	smpsc_slow_tick #(
		.DIV(smpsc_pkg::SLOW_DIV),
		.CNT_W(smpsc_pkg::SLOW_CNT_W)
	) u_tick (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.o_tick(tick)
	);

	// Input interpretation and event terms
	assign closed_now = ~(I_COMP_ABOVE ^ I_BAT_CFG); // [RULE19]
	assign any_wake_en = |I_INPUT_WAKE_EN;
	assign hot_now = |I_HOT_CELLS; // [RULE20]
	assign is_normal = (s.st == smpsc_pkg::ST_NORMAL);
	assign is_low = (s.st == smpsc_pkg::ST_LPM) ||
		(s.st == smpsc_pkg::ST_POLL);
	assign cs_fall = s.cs_q & ~I_CS_N;
	assign int_fall = s.int_q & ~I_INT_IN_N;
	assign wake_fall = s.wake_q & ~I_WAKE_IN_N & I_WAKE_PIN_EN;
	// Pin edges count only with the I/O supply up
	assign pin_wake = (cs_fall | int_fall | wake_fall) & I_IO_SUPPLY_OK; // [RULE10] [RULE11]
	assign int_exp = tick && (s.int_cnt == TMR_ONE);
	// Polling stops with no wake enables and pauses on battery undervoltage
	assign poll_run = any_wake_en & ~I_BAT_UV; // [RULE17] [RULE18]
	assign poll_exp = tick && poll_run && (s.poll_cnt == TMR_ONE); // [RULE14]
	assign in_change = |((closed_now ^ s.snap) & I_INPUT_WAKE_EN & ~s.skip);

	// Next-state logic of the operating-state machine
	always_comb begin
		next_s = s;
		next_s.wake_evt = 1'b0;
		next_s.cs_q = I_CS_N;
		next_s.int_q = I_INT_IN_N;
		next_s.wake_q = I_WAKE_IN_N;
		// Slow-tick timers run in both low-power states; the poll timer only while poll_run
		if (is_low && tick) begin // [RULE24]
			if (s.int_cnt == TMR_ONE) begin
				next_s.int_cnt = I_INT_TMR_PERIOD;
			end else if (s.int_cnt != '0) begin
				next_s.int_cnt = s.int_cnt - 1'b1;
			end
			if (poll_run) begin
				if (s.poll_cnt == TMR_ONE) begin
					next_s.poll_cnt = I_POLL_TMR_PERIOD;
				end else if (s.poll_cnt != '0) begin
					next_s.poll_cnt = s.poll_cnt - 1'b1;
				end
			end
		end
		case (s.st)
			smpsc_pkg::ST_RESET: begin
				next_s.st = smpsc_pkg::ST_UV; // [RULE1]
			end
			smpsc_pkg::ST_UV: begin
				if (!I_BAT_UV) begin // [RULE4]
					next_s.st = smpsc_pkg::ST_FUSE;
					next_s.fuse_cnt = '0;
				end
			end
			smpsc_pkg::ST_FUSE: begin
				if (I_BAT_UV) begin
					next_s.st = smpsc_pkg::ST_UV;
				end else if (s.fuse_cnt == FUSE_LAST) begin // [RULE4]
					next_s.st = smpsc_pkg::ST_NORMAL;
				end else begin
					next_s.fuse_cnt = s.fuse_cnt + 1'b1;
				end
			end
			smpsc_pkg::ST_NORMAL: begin
				if (cs_fall) begin
					next_s.int_req = 1'b0;
				end
				if (!I_CS_N && !s.cs_q) begin
					next_s.cs_woke = 1'b0;
				end
				if (I_BAT_UV) begin
					next_s.st = smpsc_pkg::ST_UV;
				end else if (I_LPM_CMD) begin // [RULE6]
					next_s.st = smpsc_pkg::ST_LPM;
					next_s.snap = closed_now;
					next_s.int_cnt = I_INT_TMR_PERIOD;
					next_s.poll_cnt = I_POLL_TMR_PERIOD;
				end
			end
			smpsc_pkg::ST_LPM, smpsc_pkg::ST_POLL: begin
				// Interrupt timer wins over a coincident poll
				if (int_exp) begin // [RULE13] [RULE15]
					next_s.st = smpsc_pkg::ST_NORMAL;
					next_s.int_req = 1'b1;
					next_s.wake_evt = 1'b1;
				end else if (pin_wake) begin // [RULE9] [RULE23]
					next_s.st = smpsc_pkg::ST_NORMAL;
					next_s.int_req = 1'b1;
					next_s.wake_evt = 1'b1;
					next_s.cs_woke = cs_fall;
				end else if (s.st == smpsc_pkg::ST_LPM) begin
					if (poll_exp) begin // [RULE14]
						next_s.st = smpsc_pkg::ST_POLL;
						next_s.win_cnt = '0;
						// Inputs open at entry and still open drop out
						next_s.skip = (~s.snap & ~closed_now) |
							~I_INPUT_WAKE_EN; // [RULE16]
					end
				end else if (I_BAT_UV) begin
					next_s.st = smpsc_pkg::ST_LPM; // [RULE17]
				end else if (tick) begin
					if (s.win_cnt == I_POLL_WIN) begin
						if (in_change) begin // [RULE9]
							next_s.st = smpsc_pkg::ST_NORMAL;
							next_s.int_req = 1'b1;
							next_s.wake_evt = 1'b1;
						end else begin
							next_s.st = smpsc_pkg::ST_LPM;
						end
					end else begin
						next_s.win_cnt = s.win_cnt + 1'b1;
					end
				end
			end
			default: begin
				next_s.st = smpsc_pkg::ST_UV;
			end
		endcase
		// Status and thermal handling; flags are set only while detectors run
		next_s.closed = closed_now; // [RULE19]
		next_s.wet = hot_now ? smpsc_pkg::WET_MIN : I_WET_SEL; // [RULE21]
		if (I_FAULT_CLR) begin
			next_s.hot = 1'b0;
			next_s.twarn = 1'b0;
		end
		// Set wins over clear; nothing is recorded in low power
		if (is_normal && hot_now) begin // [RULE7] [RULE20]
			next_s.hot = 1'b1;
		end
		if (is_normal && I_TWARN) begin // [RULE22]
			next_s.twarn = 1'b1;
		end
	end

	// State register; settings live outside and are never touched here
	always_ff @(posedge I_CLK) begin // [RULE8]
		if (!I_RST_N) begin
			s <= '{st: smpsc_pkg::ST_RESET, wet: smpsc_pkg::WET_RESET,
				cs_q: 1'b1, int_q: 1'b1, wake_q: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// Output decode from the state register
	assign O_STATE = s.st;
	assign O_SPI_EN = is_normal; // [RULE2]
	assign O_MISO_OE_N = ~is_normal; // [RULE2]
	assign O_ANALOG_MUX_OUT_EN = is_normal; // [RULE2]
	assign O_CUR_SRC_EN = is_normal ? {N{1'b1}} :
		(s.st == smpsc_pkg::ST_POLL) ? ~s.skip : '0; // [RULE16]
	assign O_FAST_OSC_EN = (s.st == smpsc_pkg::ST_UV) ||
		(s.st == smpsc_pkg::ST_FUSE) || is_normal; // [RULE3] [RULE7]
	assign O_SLOW_OSC_EN = (s.st != smpsc_pkg::ST_RESET); // [RULE3]
	assign O_RAIL_EN = (s.st == smpsc_pkg::ST_FUSE) || is_normal ||
		(s.st == smpsc_pkg::ST_POLL); // [RULE7]
	assign O_FAULT_DET_EN = is_normal; // [RULE7]
	assign O_POLL_ACTIVE = (s.st == smpsc_pkg::ST_POLL);
	assign O_WAKE_OUT = 1'b0;
	assign O_WAKE_OE_N = ~is_normal; // [RULE5] [RULE23]
	assign O_INT_OUT = 1'b0;
	assign O_INT_OE_N = ~(s.int_req & is_normal); // [RULE13]
	assign O_WAKE_EVENT = s.wake_evt;
	assign O_CS_WOKE = s.cs_woke;
	assign O_SWITCH_CLOSED = s.closed;
	assign O_HOT_FAULT = s.hot;
	assign O_TWARN_FLAG = s.twarn;
	assign O_WET_SEL = s.wet;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	a_reset_idle: assert property ((s.st == smpsc_pkg::ST_RESET) |-> // [RULE1]
		!O_SLOW_OSC_EN && !O_RAIL_EN && !O_SPI_EN)
		else $error("activity while in reset");
	a_uv_lockout: assert property ((s.st == smpsc_pkg::ST_UV) |-> // [RULE2]
		!O_SPI_EN && O_MISO_OE_N && !O_ANALOG_MUX_OUT_EN && (O_CUR_SRC_EN == '0))
		else $error("undervoltage lockout incomplete");
	a_osc_on_uv: assert property ((s.st == smpsc_pkg::ST_UV) |-> // [RULE3]
		O_FAST_OSC_EN && O_SLOW_OSC_EN)
		else $error("oscillators off in undervoltage");
	a_fuse_exit: assert property ($rose(s.st == smpsc_pkg::ST_FUSE) ##0 // [RULE4]
		(!I_BAT_UV)[*8] |-> (s.st == smpsc_pkg::ST_FUSE))
		else $error("fuse read ended too early");
	a_fuse_done: assert property (((s.st == smpsc_pkg::ST_FUSE) && // [RULE4]
		(s.fuse_cnt == FUSE_LAST) && !I_BAT_UV) |=> is_normal)
		else $error("fuse read did not end in normal mode");
	a_wake_driven: assert property (is_normal |-> // [RULE5]
		!O_WAKE_OE_N && !O_WAKE_OUT)
		else $error("wake pin not driven low in normal mode");
	a_lpm_entry: assert property (($rose(s.st == smpsc_pkg::ST_LPM) && // [RULE6]
		$past(is_normal)) |-> $past(I_LPM_CMD))
		else $error("low power entered without command");
	a_lpm_quiet: assert property (is_low |-> // [RULE7]
		!O_FAST_OSC_EN && !O_FAULT_DET_EN && !O_SPI_EN)
		else $error("fast clock or detectors active in low power");
	// A flag set on the entry edge is legal; none may appear later
	a_lpm_nofault: assert property ((is_low && !s.hot) |=> // [RULE7]
		!s.hot)
		else $error("fault recorded in low power");
	a_lpm_nowarn: assert property ((is_low && !s.twarn) |=> // [RULE7]
		!s.twarn)
		else $error("warning recorded in low power");
	a_timer_wake: assert property (((s.st == smpsc_pkg::ST_LPM) && // [RULE15]
		int_exp) |=> is_normal && !O_INT_OE_N && O_WAKE_EVENT)
		else $error("interrupt timer expiry did not wake");
	a_io_gate: assert property (((s.st == smpsc_pkg::ST_LPM) && // [RULE11]
		!I_IO_SUPPLY_OK && !int_exp && !poll_exp) |=> !is_normal)
		else $error("woke without I/O supply");
	a_poll_pause: assert property (((s.st == smpsc_pkg::ST_POLL) && // [RULE17]
		I_BAT_UV && !int_exp && !pin_wake) |=> (s.st == smpsc_pkg::ST_LPM))
		else $error("polling not paused on undervoltage");
	a_closed_map: assert property (1'b1 |=> // [RULE19]
		(O_SWITCH_CLOSED == ~($past(I_COMP_ABOVE) ^ $past(I_BAT_CFG))))
		else $error("switch state mapping wrong");
	a_hot_wet: assert property (hot_now |=> // [RULE21]
		(O_WET_SEL == smpsc_pkg::WET_MIN))
		else $error("wetting current not reduced on thermal limit");
	a_wake_pulse: assert property (O_WAKE_EVENT |-> // [RULE23]
		is_normal ##1 !O_WAKE_EVENT)
		else $error("wake report not a single pulse in normal mode");

	c_enter_lpm: cover property (is_normal ##1 (s.st == smpsc_pkg::ST_LPM));
	c_poll_back: cover property ((s.st == smpsc_pkg::ST_POLL) ##1
		(s.st == smpsc_pkg::ST_LPM));
	c_poll_wake: cover property ((s.st == smpsc_pkg::ST_POLL) ##1 is_normal);
	c_cs_wake: cover property (is_low && cs_fall && I_IO_SUPPLY_OK);
	c_timer_wake: cover property (is_low && int_exp);
endmodule : smpsc_ctrl
`default_nettype wire

// File: verilog/smpsc_pkg.sv
`default_nettype none
// Shared constants and state encoding of the operating-state controller
package smpsc_pkg;
	// Core clock
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	// Always-running slow oscillator, emulated by a divider (rounded down)
	localparam int SLOW_OSC_HZ = 192_000;
	localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
	localparam int SLOW_CNT_W = 8;
	// Fuse read time, least time rounded up to whole cycles
	localparam int FUSE_READ_US = 50;
	localparam int FUSE_CYCLES =
		(FUSE_READ_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FUSE_W = 12;
	// Channel count and timer widths
	localparam int NUM_INPUTS = 22;
	localparam int TMR_W = 16;
	localparam int WIN_W = 8;
	localparam int HOT_CELLS = 4;
	// Wetting current codes: lowest code is the 2 mA level
	localparam logic [2:0] WET_MIN = 3'h0;
	localparam logic [2:0] WET_RESET = 3'h0;
	// Operating states, one-hot
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_UV = 6'h02,
		ST_FUSE = 6'h04,
		ST_NORMAL = 6'h08,
		ST_LPM = 6'h10,
		ST_POLL = 6'h20
	} smpsc_state_t;
endpackage : smpsc_pkg
`default_nettype wire

// File: verilog/smpsc_slow_tick.sv
`timescale 1ns/10ps
`default_nettype none
// Slow time base: one-cycle tick at the slow oscillator rate, never gated
module smpsc_slow_tick #(
	parameter int DIV = smpsc_pkg::SLOW_DIV,
	parameter int CNT_W = smpsc_pkg::SLOW_CNT_W
) (
	input wire logic i_clk, // Core clock
	input wire logic i_rst_n, // Synchronous reset, active low
	output logic o_tick // One-cycle pulse per slow period
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
	} smpsc_tick_st_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

	smpsc_tick_st_t s;
	smpsc_tick_st_t next_s;

	// Divider count and tick
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == LAST) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_tick = s.tick;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_tick_single: assert property (o_tick |=> !o_tick) // [RULE24]
		else $error("slow tick lasted more than one cycle");
endmodule : smpsc_slow_tick
`default_nettype wire
